//--- logic/ppnvm_port.sv
// parallel programming port of the nonvolatile memories
//
// Behaviour
// - ready/busy low during erase or programming, high when ready
// - data bus is input except in programming mode while output enable is low
// - byte selects pick low byte at 0, high bytes at 1
// - action bits on strobe rise: address, data, command, or nothing
// - write or output enable performs the last loaded command
// - command bytes decoded for erase, writes and reads
// - entry pins changing within 100 ns of high voltage blocks entry
// - command and address retained across operations
// - erase clears flash, eeprom unless preserved, then lock bits
// - write pulse after erase command starts erase, busy low
// - data low byte with select 0, high byte with select 1
// - page load with select 1 latches data word into page buffer
// - low address bits pick word in page, upper bits the page
// - address low byte with select 0, high byte with select 1
// - write pulse programs whole flash page, busy low
// - preserve fuse is bit 3 of fuse high byte
// - flash page holds 64 words, 128 pages
`timescale 1ns/10ps
`default_nettype none
module ppnvm_port
	import ppnvm_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire ppnvm_pins_t pins,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	output logic             ready_busy_out,
	output logic             prog_mode
);
	// ------------------------------------------------------------------
	// pin synchronisers and filter
	// ------------------------------------------------------------------
	localparam int SW = $bits(ppnvm_pins_t) + 8;
	logic [SW-1:0] s1_q, s2_q, s3_q, f_q, p_q;
	wire  [SW-1:0] f_d = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q  <= '0;
			p_q  <= '0;
		end
		else
		begin
			s1_q <= {pins, data_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= f_d;
			p_q  <= f_q;
		end
	end
	ppnvm_pins_t pf, pp;
	logic [7:0]  dbus;
	assign pf   = ppnvm_pins_t'(f_q[SW-1:8]);
	assign pp   = ppnvm_pins_t'(p_q[SW-1:8]);
	assign dbus = f_q[7:0];
	wire xt_rise = pf.crystal_load_strobe & ~pp.crystal_load_strobe;
	wire wr_fall = ~pf.write_strobe_n & pp.write_strobe_n;
	wire pl_rise = pf.page_buffer_load & ~pp.page_buffer_load;
	wire hv_rise = pf.high_voltage & ~pp.high_voltage;
	wire [1:0] act = {pf.action_select_bit1, pf.action_select_bit0};
	wire [3:0] en_pins = {pf.page_buffer_load, pf.action_select_bit1,
		pf.action_select_bit0, pf.byte_select_first};
	// ------------------------------------------------------------------
	// programming mode entry
	// ------------------------------------------------------------------
	ppnvm_en_t  en_q;
	logic [2:0] tog_q;
	logic [3:0] gcnt_q;
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			en_q   <= EN_OFF;
			tog_q  <= '0;
			gcnt_q <= '0;
		end
		else if (!pf.high_voltage && !hv_rise)
		begin
			en_q   <= EN_OFF;
			gcnt_q <= '0;
			if (!pf.reset_pin_low)
				tog_q <= '0;
			else if (xt_rise && tog_q != ENTRY_TOGGLES)
				tog_q <= tog_q + 3'h1;
		end
		else
		begin
			case (en_q)
				EN_OFF:
					if (hv_rise)
						en_q <= (tog_q == ENTRY_TOGGLES && en_pins == '0)
							? EN_GUARD : EN_FAIL;
				EN_GUARD:
					if (en_pins != '0)
						en_q <= EN_FAIL;
					else if (gcnt_q == GUARD_CYC - 4'h1)
						en_q <= EN_ON;
					else
						gcnt_q <= gcnt_q + 4'h1;
				EN_ON:   en_q <= EN_ON;
				default: en_q <= EN_FAIL;
			endcase
		end
	end
	wire on = (en_q == EN_ON);
	assign prog_mode = on;
	// ------------------------------------------------------------------
	// command, address and data latches
	// ------------------------------------------------------------------
	logic [7:0]  cmd_q;
	logic [15:0] addr_q, dat_q;
	wire ld = on && xt_rise;
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cmd_q  <= '0;
			addr_q <= '0;
			dat_q  <= '0;
		end
		else if (ld)
		begin
			case (act)
				ACT_ADDR:
					if (pf.byte_select_first) addr_q[15:8] <= dbus;
					else addr_q[7:0] <= dbus;
				ACT_DATA:
					if (pf.byte_select_first) dat_q[15:8] <= dbus;
					else dat_q[7:0] <= dbus;
				ACT_CMD: cmd_q <= dbus;
				default: cmd_q <= cmd_q;
			endcase
		end
	end
	// ------------------------------------------------------------------
	// memories and page buffers
	// ------------------------------------------------------------------
	logic [15:0] fl_mem [0:(1<<FL_AW)-1];
	logic [7:0]  ee_mem [0:(1<<EE_AW)-1];
	logic [15:0] fpg [0:(1<<FL_PW)-1];
	logic [7:0]  epg [0:(1<<EE_PW)-1];
	ppnvm_st_t   st_q;
	logic [12:0] cnt_q;
	logic [7:0]  fz_lo_q, fz_hi_q, fz_ex_q, lock_q;
	wire idle = (st_q == ST_IDLE);
	wire pl_ok = on && idle && pl_rise;
	// used buffer words fall back to erased
	wire pg_clr_f = (st_q == ST_ERF) || (st_q == ST_PFL);
	wire pg_clr_e = (st_q == ST_ERF) || (st_q == ST_PEE);
	always_ff @(posedge mclk)
	begin
		if (pl_ok && cmd_q == CMD_WFLASH && pf.byte_select_first)
			fpg[addr_q[FL_PW-1:0]] <= dat_q;
		if (pl_ok && cmd_q == CMD_WEE)
			epg[addr_q[EE_PW-1:0]] <= dat_q[7:0];
		if (pg_clr_f)
			fpg[cnt_q[FL_PW-1:0]] <= WORD_ERASED;
		if (pg_clr_e)
			epg[cnt_q[EE_PW-1:0]] <= BYTE_ERASED;
	end
	wire        fl_we = (st_q == ST_ERF) || (st_q == ST_PFL);
	wire [12:0] fl_wa = (st_q == ST_ERF) ? cnt_q
		: {addr_q[FL_AW-1:FL_PW], cnt_q[FL_PW-1:0]};
	wire [15:0] fl_wd = (st_q == ST_ERF) ? WORD_ERASED : fpg[cnt_q[FL_PW-1:0]];
	wire        ee_we = (st_q == ST_ERE) || (st_q == ST_PEE);
	wire [8:0]  ee_wa = (st_q == ST_ERE) ? cnt_q[EE_AW-1:0]
		: {addr_q[EE_AW-1:EE_PW], cnt_q[EE_PW-1:0]};
	wire [7:0]  ee_wd = (st_q == ST_ERE) ? BYTE_ERASED : epg[cnt_q[EE_PW-1:0]];
	always_ff @(posedge mclk)
	begin
		if (fl_we)
			fl_mem[fl_wa] <= fl_wd;
		if (ee_we)
			ee_mem[ee_wa] <= ee_wd;
	end
	// ------------------------------------------------------------------
	// operation sequencer
	// ------------------------------------------------------------------
	wire eeprom_preserve_fuse = ~fz_hi_q[EEPROM_PRESERVE_FUSE_BIT];
	wire go = on && idle && wr_fall;
	wire [1:0] bsel = {pf.byte_select_second, pf.byte_select_first};
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			st_q    <= ST_IDLE;
			cnt_q   <= '0;
			fz_lo_q <= FUSE_LOW_RST;
			fz_hi_q <= FUSE_HIGH_RST;
			fz_ex_q <= FUSE_EXT_RST;
			lock_q  <= LOCK_RST;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					cnt_q <= '0;
					if (go)
					begin
						case (cmd_q)
							CMD_ERASE:  st_q <= ST_ERF;
							CMD_WFLASH: st_q <= ST_PFL;
							CMD_WEE:    st_q <= ST_PEE;
							CMD_WFUSE:
							begin
								st_q <= ST_SHORT;
								case (bsel)
									2'b00:   fz_lo_q <= dat_q[7:0];
									2'b01:   fz_hi_q <= dat_q[7:0];
									2'b10:   fz_ex_q <= dat_q[7:0];
									default: fz_lo_q <= fz_lo_q;
								endcase
							end
							CMD_WLOCK:
							begin
								st_q   <= ST_SHORT;
								lock_q <= lock_q & dat_q[7:0];
							end
							default: st_q <= ST_IDLE;
						endcase
					end
				end
				ST_ERF:
					if (cnt_q == FL_LAST)
					begin
						cnt_q <= '0;
						st_q  <= eeprom_preserve_fuse ? ST_ERL : ST_ERE;
					end
					else cnt_q <= cnt_q + 13'h1;
				ST_ERE:
					if (cnt_q == EE_LAST) st_q <= ST_ERL;
					else cnt_q <= cnt_q + 13'h1;
				ST_ERL:
				begin
					lock_q <= LOCK_RST;
					st_q   <= ST_IDLE;
				end
				ST_PFL:
					if (cnt_q == FPG_LAST) st_q <= ST_IDLE;
					else cnt_q <= cnt_q + 13'h1;
				ST_PEE:
					if (cnt_q == EPG_LAST) st_q <= ST_IDLE;
					else cnt_q <= cnt_q + 13'h1;
				ST_SHORT:
					if (cnt_q == SHORT_LAST) st_q <= ST_IDLE;
					else cnt_q <= cnt_q + 13'h1;
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	assign ready_busy_out = idle;
	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	wire [15:0] fl_rd = fl_mem[addr_q[FL_AW-1:0]];
	wire [7:0]  fz_rd = (bsel == 2'b00) ? fz_lo_q
		: (bsel == 2'b11) ? fz_hi_q
		: (bsel == 2'b10) ? fz_ex_q : lock_q;
	wire [7:0]  sig_rd = (addr_q[1:0] == 2'h0) ? SIG_BYTE0
		: (addr_q[1:0] == 2'h1) ? SIG_BYTE1 : SIG_BYTE2;
	wire [7:0]  rd_byte =
		(cmd_q == CMD_RFLASH) ? (pf.byte_select_first ? fl_rd[15:8] : fl_rd[7:0])
		: (cmd_q == CMD_REE)   ? ee_mem[addr_q[EE_AW-1:0]]
		: (cmd_q == CMD_RFUSE) ? fz_rd
		: (cmd_q == CMD_RSIG)  ? (pf.byte_select_first ? CAL_BYTE : sig_rd)
		: BYTE_ERASED;
	logic [7:0] dout_q;
	always_ff @(posedge mclk)
	begin
		if (srst) dout_q <= '0;
		else dout_q <= rd_byte;
	end
	assign data_out = dout_q;
	assign data_oe  = on && !pf.output_enable_n;
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	AST_ERASE_BUSY: assert property (go && cmd_q == CMD_ERASE |=> !ready_busy_out [*8])
		else $error("erase did not hold busy");
	AST_PAGE_BUSY: assert property (
		go && cmd_q == CMD_WFLASH |=> !ready_busy_out ##64 ready_busy_out)
		else $error("page program busy length wrong");
	AST_OE: assert property (data_oe |-> on && !pf.output_enable_n)
		else $error("bus driven without output enable");
	AST_CMD_LOAD: assert property (ld && act == ACT_CMD |=> cmd_q == $past(dbus))
		else $error("command not loaded");
	AST_ADDR_HI: assert property (ld && act == ACT_ADDR && pf.byte_select_first
		|=> addr_q[15:8] == $past(dbus) && $stable(addr_q[7:0]))
		else $error("address high byte load wrong");
	AST_DATA_HI: assert property (ld && act == ACT_DATA && pf.byte_select_first
		|=> dat_q[15:8] == $past(dbus))
		else $error("data high byte load wrong");
	AST_CMD_KEEP: assert property (!(ld && act == ACT_CMD) |=> $stable(cmd_q))
		else $error("command changed without load");
	AST_BUSY_IGNORE: assert property (
		st_q == ST_ERF && cnt_q != FL_LAST && wr_fall
		|=> st_q == ST_ERF && cnt_q == $past(cnt_q) + 13'h1)
		else $error("write taken while busy");
	AST_LOCK_LATE: assert property (st_q == ST_ERF |=> $stable(lock_q))
		else $error("lock bits cleared before flash erased");
	AST_GUARD: assert property (en_q == EN_GUARD && en_pins != '0 |=> !prog_mode [*2])
		else $error("entry despite pin activity");
	CV_ERASE: cover property (st_q == ST_ERL ##1 ready_busy_out);
	CV_PAGE:  cover property (st_q == ST_PFL ##1 st_q == ST_IDLE);
	CV_ENTRY: cover property (en_q == EN_GUARD ##1 en_q == EN_ON);
	CV_READ:  cover property (data_oe && cmd_q == CMD_RFLASH);
endmodule : ppnvm_port
`default_nettype wire

//--- logic/ppnvm_pkg.sv
// constants and types for the parallel programming port
package ppnvm_pkg;
	// ------------------------------------------------------------------
	// command bytes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_ERASE  = 8'h80;
	localparam logic [7:0] CMD_WFUSE  = 8'h40;
	localparam logic [7:0] CMD_WLOCK  = 8'h20;
	localparam logic [7:0] CMD_WFLASH = 8'h10;
	localparam logic [7:0] CMD_WEE    = 8'h11;
	localparam logic [7:0] CMD_RSIG   = 8'h08;
	localparam logic [7:0] CMD_RFUSE  = 8'h04;
	localparam logic [7:0] CMD_RFLASH = 8'h02;
	localparam logic [7:0] CMD_REE    = 8'h03;
	// ------------------------------------------------------------------
	// action select codes
	// ------------------------------------------------------------------
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	// ------------------------------------------------------------------
	// memory geometry
	// ------------------------------------------------------------------
	localparam int FL_AW  = 13;
	localparam int FL_PW  = 6;
	localparam int EE_AW  = 9;
	localparam int EE_PW  = 2;
	localparam logic [12:0] FL_LAST  = 13'h1fff;
	localparam logic [12:0] EE_LAST  = 13'h01ff;
	localparam logic [12:0] FPG_LAST = 13'h003f;
	localparam logic [12:0] EPG_LAST = 13'h0003;
	localparam logic [12:0] SHORT_LAST = 13'h000f;
	localparam logic [15:0] WORD_ERASED = 16'hffff;
	localparam logic [7:0]  BYTE_ERASED = 8'hff;
	// ------------------------------------------------------------------
	// fuse and lock reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] FUSE_LOW_RST  = 8'h62;
	localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
	localparam logic [7:0] FUSE_EXT_RST  = 8'hff;
	localparam logic [7:0] LOCK_RST      = 8'hff;
	localparam int         EEPROM_PRESERVE_FUSE_BIT    = 3;
	// arbitrary identity values
	localparam logic [7:0] SIG_BYTE0 = 8'h5a;
	localparam logic [7:0] SIG_BYTE1 = 8'h01;
	localparam logic [7:0] SIG_BYTE2 = 8'h02;
	localparam logic [7:0] CAL_BYTE  = 8'h80;
	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int         CLK_NS    = 8;
	localparam int         GUARD_NS  = 100;
	localparam logic [3:0] GUARD_CYC = 4'((GUARD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] ENTRY_TOGGLES = 3'h6;
	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic crystal_load_strobe;
		logic write_strobe_n;
		logic output_enable_n;
		logic page_buffer_load;
		logic byte_select_first;
		logic byte_select_second;
		logic action_select_bit1;
		logic action_select_bit0;
		logic reset_pin_low;
		logic high_voltage;
	} ppnvm_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ERF   = 3'b001,
		ST_ERE   = 3'b010,
		ST_ERL   = 3'b011,
		ST_PFL   = 3'b100,
		ST_PEE   = 3'b101,
		ST_SHORT = 3'b110
	} ppnvm_st_t;

	typedef enum logic [1:0] {
		EN_OFF   = 2'b00,
		EN_GUARD = 2'b01,
		EN_ON    = 2'b10,
		EN_FAIL  = 2'b11
	} ppnvm_en_t;
endpackage : ppnvm_pkg

//--- sim/ppnvm_prog.sv
// programmer model driving the strobes and the data bus
`timescale 1ns/10ps
`default_nettype none
module ppnvm_prog
	import ppnvm_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe,
	output var  ppnvm_pins_t pins,
	output logic      [7:0]  data_in
);
	logic [7:0] drv;
	logic       drv_en;
	// ------------------------------------------------------------------
	// bus level: released bus shows port output while data_oe is high, else inverse of last drive
	// ------------------------------------------------------------------
	assign data_in = drv_en ? drv : (data_oe ? data_out : ~drv);
	initial
	begin
		pins = '0;
		pins.write_strobe_n = 1'b1;
		pins.output_enable_n = 1'b1;
		drv = 8'h00;
		drv_en = 1'b1;
	end
	// ------------------------------------------------------------------
	// strobe tasks
	// ------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic strobe();
		pins.crystal_load_strobe <= 1'b1;
		tick(32);
		pins.crystal_load_strobe <= 1'b0;
		tick(32);
	endtask : strobe
	task automatic enter(input logic bad);
		pins.reset_pin_low <= 1'b1;
		repeat (6) strobe();
		pins.page_buffer_load <= 1'b0;
		pins.action_select_bit1 <= 1'b0;
		pins.action_select_bit0 <= 1'b0;
		pins.byte_select_first <= 1'b0;
		tick(16);
		pins.high_voltage <= 1'b1;
		tick(2);
		pins.byte_select_first <= bad;
		tick(40);
		pins.byte_select_first <= 1'b0;
		if (!bad)
		begin
			tick(6250);
		end
	endtask : enter
	task automatic leave();
		pins.high_voltage <= 1'b0;
		tick(16);
	endtask : leave
	task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] b);
		pins.action_select_bit1 <= act[1];
		pins.action_select_bit0 <= act[0];
		pins.byte_select_first <= bs1;
		drv <= b;
		tick(8);
		strobe();
	endtask : load
	task automatic wr();
		pins.write_strobe_n <= 1'b0;
		tick(32);
		pins.write_strobe_n <= 1'b1;
	endtask : wr
	task automatic pgl();
		pins.byte_select_first <= 1'b1;
		pins.page_buffer_load <= 1'b1;
		tick(32);
		pins.page_buffer_load <= 1'b0;
		tick(32);
	endtask : pgl
	task automatic rd(input logic bs2, input logic bs1, output logic [7:0] b);
		pins.byte_select_second <= bs2;
		pins.byte_select_first <= bs1;
		pins.output_enable_n <= 1'b0;
		drv_en <= 1'b0;
		tick(10);
		b = data_in;
		pins.output_enable_n <= 1'b1;
		drv_en <= 1'b1;
		tick(10);
	endtask : rd
endmodule : ppnvm_prog
`default_nettype wire

//--- sim/ppnvm_port_bench.sv
// self-checking bench for the parallel programming port
`timescale 1ns/10ps
`default_nettype none
module ppnvm_port_bench
	import ppnvm_pkg::*;
;
	logic        mclk;
	logic        srst;
	ppnvm_pins_t pins;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic        data_oe;
	logic        ready_busy_out;
	logic        prog_mode;
	int          n_mismatch;
	int          compares;
	logic [7:0]  rb;

	ppnvm_port i_dut (.mclk(mclk), .srst(srst), .pins(pins), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .ready_busy_out(ready_busy_out),
		.prog_mode(prog_mode));
	ppnvm_prog i_prog (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
		.pins(pins), .data_in(data_in));
	// ------------------------------------------------------------------
	// compare and helper tasks
	// ------------------------------------------------------------------
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp1
	task automatic wait_ready();
		int k;
		k = 0;
		while (ready_busy_out !== 1'b1 && k < 10000)
		begin
			i_prog.tick(1);
			k++;
		end
		cmp1(ready_busy_out, 1'b1);
		i_prog.tick(8);
	endtask : wait_ready
	task automatic rd_cmp(input logic bs2, input logic bs1, input logic [7:0] exp);
		i_prog.rd(bs2, bs1, rb);
		cmp8(rb, exp);
	endtask : rd_cmp
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_entry();
		cmp1(prog_mode, 1'b0);
		i_prog.enter(1'b1);
		cmp1(prog_mode, 1'b0);
		i_prog.leave();
		i_prog.enter(1'b0);
		cmp1(prog_mode, 1'b1);
		cmp1(ready_busy_out, 1'b1);
		$display("entry test done");
	endtask : t_entry
	task automatic t_erase();
		i_prog.load(ACT_CMD, 1'b0, CMD_ERASE);
		i_prog.wr();
		cmp1(ready_busy_out, 1'b0);
		i_prog.tick(32);
		i_prog.wr();
		cmp1(ready_busy_out, 1'b0);
		wait_ready();
		i_prog.load(ACT_CMD, 1'b0, CMD_REE);
		i_prog.load(ACT_ADDR, 1'b1, 8'h00);
		i_prog.load(ACT_ADDR, 1'b0, 8'h02);
		rd_cmp(1'b0, 1'b0, BYTE_ERASED);
		i_prog.load(ACT_CMD, 1'b0, CMD_RFLASH);
		i_prog.load(ACT_ADDR, 1'b0, 8'h05);
		rd_cmp(1'b0, 1'b0, 8'hff);
		rd_cmp(1'b0, 1'b1, 8'hff);
		cmp1(data_oe, 1'b0);
		$display("erase test done");
	endtask : t_erase
	task automatic t_flash();
		i_prog.load(ACT_CMD, 1'b0, CMD_WFLASH);
		i_prog.load(ACT_ADDR, 1'b1, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			i_prog.load(ACT_ADDR, 1'b0, 8'(i));
			i_prog.load(ACT_DATA, 1'b0, 8'ha0 + 8'(i));
			i_prog.load(ACT_DATA, 1'b1, 8'h3c + 8'(i));
			i_prog.pgl();
		end
		i_prog.wr();
		cmp1(ready_busy_out, 1'b0);
		wait_ready();
		i_prog.load(ACT_CMD, 1'b0, CMD_RFLASH);
		for (int i = 0; i < 2; i++)
		begin
			i_prog.load(ACT_ADDR, 1'b0, 8'(i));
			rd_cmp(1'b0, 1'b0, 8'ha0 + 8'(i));
			rd_cmp(1'b0, 1'b1, 8'h3c + 8'(i));
		end
		i_prog.load(2'h3, 1'b0, CMD_ERASE);
		rd_cmp(1'b0, 1'b1, 8'h3d);
		i_prog.load(ACT_ADDR, 1'b0, 8'h02);
		rd_cmp(1'b0, 1'b0, BYTE_ERASED);
		$display("flash test done");
	endtask : t_flash
	task automatic t_reads();
		i_prog.load(ACT_CMD, 1'b0, CMD_RFUSE);
		rd_cmp(1'b1, 1'b1, FUSE_HIGH_RST);
		rd_cmp(1'b0, 1'b0, FUSE_LOW_RST);
		rd_cmp(1'b1, 1'b0, FUSE_EXT_RST);
		rd_cmp(1'b0, 1'b1, 8'hff);
		i_prog.load(ACT_CMD, 1'b0, CMD_RSIG);
		i_prog.load(ACT_ADDR, 1'b0, 8'h00);
		rd_cmp(1'b0, 1'b0, SIG_BYTE0);
		rd_cmp(1'b0, 1'b1, CAL_BYTE);
		$display("read test done");
	endtask : t_reads
	task automatic t_writes();
		i_prog.load(ACT_CMD, 1'b0, CMD_WEE);
		i_prog.load(ACT_ADDR, 1'b0, 8'h05);
		i_prog.load(ACT_DATA, 1'b0, 8'h6b);
		i_prog.pgl();
		i_prog.wr();
		wait_ready();
		i_prog.load(ACT_CMD, 1'b0, CMD_REE);
		rd_cmp(1'b0, 1'b0, 8'h6b);
		i_prog.load(ACT_CMD, 1'b0, CMD_WFUSE);
		i_prog.load(ACT_DATA, 1'b0, 8'h91);
		i_prog.load(2'h3, 1'b1, 8'h00);
		i_prog.wr();
		wait_ready();
		i_prog.load(ACT_CMD, 1'b0, CMD_WLOCK);
		i_prog.load(ACT_DATA, 1'b0, 8'hfc);
		i_prog.wr();
		wait_ready();
		i_prog.load(ACT_CMD, 1'b0, CMD_RFUSE);
		rd_cmp(1'b1, 1'b1, 8'h91);
		rd_cmp(1'b0, 1'b1, 8'hfc);
		i_prog.load(ACT_CMD, 1'b0, CMD_ERASE);
		i_prog.wr();
		wait_ready();
		i_prog.load(ACT_CMD, 1'b0, CMD_RFUSE);
		rd_cmp(1'b0, 1'b1, LOCK_RST);
		rd_cmp(1'b1, 1'b1, 8'h91);
		i_prog.load(ACT_CMD, 1'b0, CMD_REE);
		rd_cmp(1'b0, 1'b0, 8'h6b);
		i_prog.load(ACT_CMD, 1'b0, CMD_RFLASH);
		i_prog.load(ACT_ADDR, 1'b0, 8'h00);
		rd_cmp(1'b0, 1'b1, 8'hff);
		$display("write test done");
	endtask : t_writes
	// ------------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial
	begin
		srst = 1'b1;
		n_mismatch = 0;
		compares = 0;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		i_prog.tick(2);
		t_entry();
		t_erase();
		t_flash();
		t_reads();
		t_writes();
		summarize();
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		summarize();
	end
endmodule : ppnvm_port_bench
`default_nettype wire
